/* verif/brake_sequence_controller_tb.sv */
// Self-checking bench of the brake sequence controller.
// Assumes bsc_defs.svh on the include path and the brake model beside it.
`timescale 1ns/100ps
`default_nettype none
module brake_sequence_controller_tb;
  logic        clk = 1'b0, sys_rst = 1'b1;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        network_mode = 1'b0, start_cmd = 1'b0, fb_ok = 1'b1;
  logic [15:0] speed_command = 16'h0000, output_frequency = 16'h0000;
  logic [15:0] output_current = 16'h0000, starting_frequency_setting = 16'h001e;
  logic [3:0]  term_hi = 4'h0;
  logic [2:0]  open_collector_output;
  logic        accel_enable, hold_frequency, output_shutoff, trip;
  logic        auto_restart_enable, second_function_active, brake_fb;
  wire logic [4:0] input_terminals;
  int          bad_count = 0, n_checks = 0, cycles = 0;
  assign input_terminals = {term_hi, brake_fb & fb_ok};
  bsc_top dut_u (.clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .network_mode, .start_cmd, .speed_command, .output_frequency, .output_current,
    .starting_frequency_setting, .input_terminals, .open_collector_output, .accel_enable,
    .hold_frequency, .output_shutoff, .trip, .auto_restart_enable, .second_function_active);
  bsc_brake_model #(.DELAY(8)) brake_u (.clk(clk), .release_req(open_collector_output[0]),
    .released(brake_fb));
  ////////////////////////////////////////
  // Clock and a ceiling on the run, so a hung handshake still ends in a verdict.
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count = bad_count + 1;
      wrap_up();
    end
  end
  ////////////////////////////////////////
  // Shared comparison, bus cycles and bounded waits.
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      bad_count = bad_count + 1;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge clk); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    check("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [3:0] a, input logic [31:0] exp);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    check("rdata", s_axi_rdata, exp);
    s_axi_rready <= 1'b0;
  endtask
  // Waits a bounded time for one output to reach a level, then compares it.
  task automatic expect_bit(input int sel, input logic v, input string what);
    logic s;
    for (int i = 0; i < 200; i++) begin
      @(posedge clk);
      s = sel == 0 ? open_collector_output[0] : sel == 1 ? accel_enable :
          sel == 2 ? hold_frequency : output_shutoff;
      if (s === v) break;
    end
    check(what, {31'h0, s}, {31'h0, v});
  endtask
  // Whole lift and lower cycle; timers are zero so the 0.1 s tick is never awaited.
  task automatic run_seq(input logic [7:0] mode);
    axi_write(4'h8, {mode, 24'h00_0000}, 2'b00);
    speed_command <= 16'h0190;
    output_current <= 16'h0578;
    output_frequency <= 16'h012c;
    start_cmd <= 1'b1;
    expect_bit(0, 1'b1, "request on");
    if (mode == 8'h07) expect_bit(2, 1'b1, "wait feedback");
    expect_bit(1, 1'b1, "accelerate");
    term_hi[0] <= 1'b1;
    repeat (6) @(posedge clk);
    check("second ignored", {31'h0, second_function_active}, 32'h0);
    term_hi[0] <= 1'b0;
    start_cmd <= 1'b0;
    output_frequency <= 16'h0258;
    expect_bit(0, 1'b0, "request off");
    output_frequency <= 16'h012c;
    expect_bit(2, 1'b1, "hold release");
    expect_bit(2, 1'b0, "resume");
    output_frequency <= 16'h0028;
    repeat (6) @(posedge clk);
    check("not yet stopped", {31'h0, output_shutoff}, 32'h0);
    output_frequency <= 16'h001e;
    expect_bit(3, 1'b1, "stopped");
    $display("test mode %0d done", mode);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // Main sequence.
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    axi_read(4'h0, 32'h0258_012c);
    axi_read(4'h4, 32'h0000_0514);
    axi_read(4'h8, 32'h0003_0303);
    check("restart mode 0", {31'h0, auto_restart_enable}, 32'h1);
    axi_write(4'h0, 32'h0064_00c8, 2'b10);
    axi_write(4'h0, 32'h0bb9_012c, 2'b10);
    axi_write(4'h4, 32'h0000_07d1, 2'b10);
    axi_write(4'h4, 32'h0000_07d0, 2'b00);
    axi_write(4'h4, 32'h0000_0514, 2'b00);
    axi_read(4'h0, 32'h0258_012c);
    axi_write(4'hc, 32'h0000_140f, 2'b00);
    axi_write(4'h8, 32'h0800_0000, 2'b00);
    check("restart mode 8", {31'h0, auto_restart_enable}, 32'h0);
    start_cmd <= 1'b1;
    speed_command <= 16'h0190;
    output_current <= 16'h0578;
    repeat (20) @(posedge clk);
    check("offline request", {31'h0, open_collector_output[0]}, 32'h0);
    check("offline accel", {31'h0, accel_enable}, 32'h1);
    start_cmd <= 1'b0;
    network_mode <= 1'b1;
    $display("test registers done");
    run_seq(8'h08);
    run_seq(8'h07);
    start_cmd <= 1'b1;
    expect_bit(1, 1'b1, "run again");
    fb_ok <= 1'b0;
    expect_bit(3, 1'b1, "lost trips");
    axi_read(4'h4, 32'h0004_0514);
    check("trip", {31'h0, trip}, 32'h1);
    start_cmd <= 1'b0;
    axi_write(4'hc, 32'h0000_780f, 2'b00);
    expect_bit(0, 1'b1, "inverted request");
    term_hi[0] <= 1'b1;
    repeat (6) @(posedge clk);
    check("second at stop", {31'h0, second_function_active}, 32'h1);
    wrap_up();
  end
endmodule
`default_nettype wire

/* verif/bsc_brake_model.sv */
// Behavioural mechanical brake with its released contact.
// Assumes the release request arrives active high on clk.
`timescale 1ns/100ps
`default_nettype none
module bsc_brake_model #(parameter int DELAY = 8) (
  input  wire logic clk,
  input  wire logic release_req,
  output logic      released
);
  int cnt = 0;
  initial released = 1'b0;
  // The contact follows the request only after a mechanical delay, never at once.
  always @(posedge clk) begin
    if (release_req !== released) begin
      cnt <= cnt + 1;
      if (cnt == DELAY) begin
        released <= release_req;
        cnt <= 0;
      end
    end else begin
      cnt <= 0;
    end
  end
endmodule
`default_nettype wire

/* verif/bsc_properties.sv */
// Port checker of the brake sequence controller.
// Assumes it is bound into bsc_top and sees only its ports.
`timescale 1ns/100ps
`default_nettype none
module bsc_properties (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        network_mode,
  input wire logic        accel_enable,
  input wire logic        hold_frequency,
  input wire logic        output_shutoff,
  input wire logic        trip
);
  // All checks share the one clock and its reset.
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  // A register answer comes one cycle after it is taken and stands until taken.
  chk_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid |=> s_axi_bvalid)
    else $error("write answer late");
  chk_write_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  chk_read_answer: assert property (s_axi_arvalid && !s_axi_rvalid |=> s_axi_rvalid)
    else $error("read answer late");
  chk_read_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  // A trip shuts the output off and stops both holding and acceleration.
  chk_trip_shutoff: assert property (trip |-> output_shutoff)
    else $error("trip without shutoff");
  chk_trip_stops: assert property (trip |-> !accel_enable && !hold_frequency)
    else $error("trip still driving");
  chk_hold_no_accel: assert property (hold_frequency |-> !accel_enable)
    else $error("hold and accelerate together");
  // Outside network operation the sequence must not hold the motor back.
  chk_network_off: assert property (!network_mode [*3] |-> accel_enable && !hold_frequency)
    else $error("sequence active offline");
endmodule
bind bsc_top bsc_properties chk_u (.clk, .sys_rst, .s_axi_awvalid, .s_axi_wvalid, .s_axi_bvalid,
  .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
  .network_mode, .accel_enable, .hold_frequency, .output_shutoff, .trip);
`default_nettype wire

/* verilog/bsc_defs.svh */
// Constants of the brake sequence controller: settings, codes, timing counts.
// Assumes a 25 MHz clock; frequencies in 0.01 Hz, currents in 0.1 percent, times in 0.1 s.
`ifndef BSC_DEFS_SVH
`define BSC_DEFS_SVH
`define BSC_CLK_HZ            32'd25000000
`define BSC_TICK_S_TENTHS     32'd1
`define BSC_TICK_CYCLES       ((`BSC_CLK_HZ / 32'd10) * `BSC_TICK_S_TENTHS)
`define BSC_MODE_NORMAL       8'h00
`define BSC_MODE_SHORT1       8'h01
`define BSC_MODE_SHORT11      8'h0B
`define BSC_MODE_FEEDBACK     8'h07
`define BSC_MODE_NO_FEEDBACK  8'h08
`define BSC_IN_SEL_FEEDBACK   8'h0F
`define BSC_OUT_SEL_POS       8'h14
`define BSC_OUT_SEL_NEG       8'h78
`define BSC_FREQ_MAX          16'h0BB8
`define BSC_CUR_MAX           16'h07D0
`define BSC_CUR_RATED         16'h03E8
`define BSC_STOP_FREQ_MIN     16'h0032
`define BSC_FAULT_TIME        8'h14
`define BSC_REL_FREQ_RST      16'h012C
`define BSC_ENG_FREQ_RST      16'h0258
`define BSC_REL_CUR_RST       16'h0514
`define BSC_DET_TIME_RST      8'h03
`define BSC_START_TIME_RST    8'h03
`define BSC_STOP_TIME_RST     8'h03
`define BSC_N_INPUTS          5
`define BSC_N_OUTPUTS         3
`endif

/* verilog/bsc_pkg.sv */
// Types of the brake sequence controller.
// Assumes bsc_defs.svh is on the include path.
package bsc_pkg;
  typedef enum logic [3:0] {
    BSC_IDLE     = 4'b0000,
    BSC_WAIT_CUR = 4'b0001,
    BSC_DETECT   = 4'b0010,
    BSC_WAIT_FB  = 4'b0011,
    BSC_START    = 4'b0100,
    BSC_RUN      = 4'b0101,
    BSC_DECEL    = 4'b0110,
    BSC_WAIT_OFF = 4'b0111,
    BSC_HOLD     = 4'b1000,
    BSC_FINAL    = 4'b1001,
    BSC_FAULT    = 4'b1010
  } bsc_state_t;
endpackage

/* verilog/bsc_sync.sv */
// Two-flop synchroniser for one level from outside the clock domain.
// Assumes the input is a slow level such as a contact.
`timescale 1ns/100ps
`default_nettype none
module bsc_sync (
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic d,
  output logic      q
);
  logic meta;

  // The first flop feeds only the second; nothing else reads it.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      meta <= 1'b0;
      q    <= 1'b0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end
endmodule
`default_nettype wire

/* verilog/bsc_tick.sv */
// Common 0.1 s time base for all sequence timers.
// Assumes one free-running system clock.
`timescale 1ns/100ps
`default_nettype none
`include "bsc_defs.svh"
module bsc_tick (
  input  wire logic clk,
  input  wire logic sys_rst,
  output logic      tick
);
  localparam logic [23:0] LAST = 24'(`BSC_TICK_CYCLES - 32'd1);
  logic [23:0] count;
  logic [23:0] next_count;
  logic        next_tick;

  // Counter wraps each tenth of a second and pulses tick for one cycle.
  always_comb begin
    next_tick  = (count == LAST);
    next_count = next_tick ? 24'h00_0000 : count + 24'h00_0001;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= 24'h00_0000;
      tick  <= 1'b0;
    end else begin
      count <= next_count;
      tick  <= next_tick;
    end
  end
endmodule
`default_nettype wire

/* verilog/bsc_top.sv */
// Brake sequence controller with an AXI4-Lite register slave.
// Assumes speed, current and frequency come from drive logic on clk; pins are asynchronous.
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "bsc_defs.svh"
module bsc_top
  import bsc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        network_mode,
  input  wire logic        start_cmd,
  input  wire logic [15:0] speed_command,
  input  wire logic [15:0] output_frequency,
  input  wire logic [15:0] output_current,
  input  wire logic [15:0] starting_frequency_setting,
  input  wire logic [4:0]  input_terminals,
  output logic [2:0]       open_collector_output,
  output logic             accel_enable,
  output logic             hold_frequency,
  output logic             output_shutoff,
  output logic             trip,
  output logic             auto_restart_enable,
  output logic             second_function_active
);
  // Register offsets; each word is aligned.
  localparam logic [3:0] A_FREQ = 4'h0;
  localparam logic [3:0] A_CUR  = 4'h4;
  localparam logic [3:0] A_TIME = 4'h8;
  localparam logic [3:0] A_SEL  = 4'hC;

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and shared tick.

  logic [4:0] term_sync;
  logic       tick;

  genvar gi;
  generate
    for (gi = 0; gi < `BSC_N_INPUTS; gi = gi + 1) begin : g_sync
      bsc_sync u_sync (
        .clk     (clk),
        .sys_rst (sys_rst),
        .d       (input_terminals[gi]),
        .q       (term_sync[gi])
      );
    end
  endgenerate

  bsc_tick u_tick (
    .clk     (clk),
    .sys_rst (sys_rst),
    .tick    (tick)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Register bank and AXI4-Lite slave.

  logic [15:0] release_frequency_setting;
  logic [15:0] engage_frequency_setting;
  logic [15:0] release_current_setting;
  logic [7:0]  current_detection_time;
  logic [7:0]  start_brake_time;
  logic [7:0]  stop_brake_time;
  logic [7:0]  sequence_mode_setting;
  logic [39:0] input_function_selectors;
  logic [23:0] output_function_selectors;
  logic [3:0]  fault_flags;
  logic [31:0] rd_word;
  logic [1:0]  rd_resp;
  logic [15:0] next_release_frequency_setting;
  logic [15:0] next_engage_frequency_setting;
  logic [15:0] next_release_current_setting;
  logic [7:0]  next_current_detection_time;
  logic [7:0]  next_start_brake_time;
  logic [7:0]  next_stop_brake_time;
  logic [7:0]  next_sequence_mode_setting;
  logic [39:0] next_input_function_selectors;
  logic [23:0] next_output_function_selectors;
  logic        next_bvalid, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic        do_write, do_read;
  logic [15:0] wf_rel, wf_eng;

  // Address and data are taken together so a write needs both channels valid.
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_wready  = s_axi_awready;
  assign s_axi_arready = s_axi_arvalid && !s_axi_rvalid;
  assign do_write      = s_axi_awready;
  assign do_read       = s_axi_arready;

  // Write decode; a rejected frequency pair answers SLVERR and changes nothing.
  always_comb begin
    next_release_frequency_setting = release_frequency_setting;
    next_engage_frequency_setting  = engage_frequency_setting;
    next_release_current_setting   = release_current_setting;
    next_current_detection_time    = current_detection_time;
    next_start_brake_time          = start_brake_time;
    next_stop_brake_time           = stop_brake_time;
    next_sequence_mode_setting     = sequence_mode_setting;
    next_input_function_selectors  = input_function_selectors;
    next_output_function_selectors = output_function_selectors;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp  = s_axi_bresp;
    wf_rel = s_axi_wdata[15:0];
    wf_eng = s_axi_wdata[31:16];
    if (do_write) begin
      next_bvalid = 1'b1;
      next_bresp  = 2'b00;
      case (s_axi_awaddr)
        A_FREQ: begin
          if (wf_rel <= wf_eng && wf_eng <= `BSC_FREQ_MAX && s_axi_wstrb == 4'hF) begin
            next_release_frequency_setting = wf_rel;
            next_engage_frequency_setting  = wf_eng;
          end else begin
            next_bresp = 2'b10;
          end
        end
        A_CUR: begin
          if (s_axi_wdata[15:0] <= `BSC_CUR_MAX) begin
            next_release_current_setting = s_axi_wdata[15:0];
          end else begin
            next_bresp = 2'b10;
          end
        end
        A_TIME: begin
          next_current_detection_time = s_axi_wdata[7:0];
          next_start_brake_time       = s_axi_wdata[15:8];
          next_stop_brake_time        = s_axi_wdata[23:16];
          next_sequence_mode_setting  = s_axi_wdata[31:24];
        end
        A_SEL: begin
          next_input_function_selectors[7:0]  = s_axi_wdata[7:0];
          next_output_function_selectors[7:0] = s_axi_wdata[15:8];
        end
        default: next_bresp = 2'b10;
      endcase
    end
  end

  // Read decode; unmapped addresses answer SLVERR with zero data.
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_resp = 2'b00;
    case (s_axi_araddr)
      A_FREQ: rd_word = {engage_frequency_setting, release_frequency_setting};
      A_CUR:  rd_word = {8'h00, 4'h0, fault_flags, release_current_setting};
      A_TIME: rd_word = {sequence_mode_setting, stop_brake_time,
                         start_brake_time, current_detection_time};
      A_SEL:  rd_word = {8'h00, 8'h00, output_function_selectors[7:0],
                         input_function_selectors[7:0]};
      default: rd_resp = 2'b10;
    endcase
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (do_read) begin
      next_rvalid = 1'b1;
      next_rdata  = rd_word;
      next_rresp  = rd_resp;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      release_frequency_setting <= `BSC_REL_FREQ_RST;
      engage_frequency_setting  <= `BSC_ENG_FREQ_RST;
      release_current_setting   <= `BSC_REL_CUR_RST;
      current_detection_time    <= `BSC_DET_TIME_RST;
      start_brake_time          <= `BSC_START_TIME_RST;
      stop_brake_time           <= `BSC_STOP_TIME_RST;
      sequence_mode_setting     <= `BSC_MODE_NORMAL;
      input_function_selectors  <= 40'h00_0000_0000;
      output_function_selectors <= 24'h00_0000;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else begin
      release_frequency_setting <= next_release_frequency_setting;
      engage_frequency_setting  <= next_engage_frequency_setting;
      release_current_setting   <= next_release_current_setting;
      current_detection_time    <= next_current_detection_time;
      start_brake_time          <= next_start_brake_time;
      stop_brake_time           <= next_stop_brake_time;
      sequence_mode_setting     <= next_sequence_mode_setting;
      input_function_selectors  <= next_input_function_selectors;
      output_function_selectors <= next_output_function_selectors;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp  <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Terminal routing and mode decode.

  logic feedback;
  logic second_sel;
  logic mode_fb, mode_nofb, seq_selected, seq_active;
  logic stop_freq_hit;
  logic [15:0] stop_freq;
  logic [25:0] cur_limit;

  // Feedback comes from terminal 0 (selector register); second function uses terminal 1.
  assign feedback   = (input_function_selectors[7:0] == `BSC_IN_SEL_FEEDBACK)
                      ? term_sync[0] : 1'b0;
  assign second_sel = term_sync[1];

  assign mode_fb      = (sequence_mode_setting == `BSC_MODE_FEEDBACK);
  assign mode_nofb    = (sequence_mode_setting == `BSC_MODE_NO_FEEDBACK);
  assign seq_selected = mode_fb || mode_nofb;
  assign auto_restart_enable = !seq_selected;

  // Release current is scaled to rated current, 1000 tenths of a percent.
  assign cur_limit = 26'(release_current_setting) * 26'(`BSC_CUR_RATED);

  // Stop point is the lower of the starting frequency and 0.5 Hz.
  assign stop_freq = (starting_frequency_setting < `BSC_STOP_FREQ_MIN)
                     ? starting_frequency_setting : `BSC_STOP_FREQ_MIN;
  assign stop_freq_hit = (output_frequency <= stop_freq);

  //////////////////////////////////////////////////////////////////////////////
  // Sequence state machine with timers.

  bsc_state_t state, next_state;
  logic [7:0] timer, next_timer;
  logic [7:0] flt_timer, next_flt_timer;
  logic [3:0] next_fault_flags;
  logic       release_req, next_release_req;
  logic       sec_latch, next_sec_latch;

  function automatic logic elapsed(input logic [7:0] t, input logic [7:0] limit);
    elapsed = (t >= limit);
  endfunction

  assign seq_active = seq_selected && network_mode && !sec_latch;

  // Timer counts in ticks and is cleared on every state change.
  always_comb begin
    next_state       = state;
    next_release_req = release_req;
    next_fault_flags = fault_flags;
    next_sec_latch   = sec_latch;
    next_timer       = tick ? timer + 8'h01 : timer;
    next_flt_timer   = tick ? flt_timer + 8'h01 : flt_timer;
    if (timer == 8'hFF) next_timer = timer;
    if (flt_timer == 8'hFF) next_flt_timer = flt_timer;
    // Second function is sampled only at a stop, so it cannot abort a run.
    if (state == BSC_IDLE) next_sec_latch = second_sel;
    case (state)
      BSC_IDLE: begin
        next_release_req = 1'b0;
        next_flt_timer = 8'h00;
        if (start_cmd && seq_active) next_state = BSC_WAIT_CUR;
      end
      BSC_WAIT_CUR: begin
        next_timer = 8'h00;
        if (speed_command >= release_frequency_setting &&
            26'(output_current) * 26'd1000 >= cur_limit) next_state = BSC_DETECT;
      end
      BSC_DETECT: begin
        if (!(speed_command >= release_frequency_setting &&
              26'(output_current) * 26'd1000 >= cur_limit)) begin
          next_state = BSC_WAIT_CUR;
        end else if (elapsed(timer, current_detection_time)) begin
          next_release_req = 1'b1;
          next_flt_timer = 8'h00;
          next_timer = 8'h00;
          next_state = mode_fb ? BSC_WAIT_FB : BSC_START;
        end
      end
      BSC_WAIT_FB: begin
        next_timer = 8'h00;
        if (feedback) begin
          next_state = BSC_START;
        end else if (flt_timer > `BSC_FAULT_TIME) begin
          next_fault_flags[1] = 1'b1;
          next_state = BSC_FAULT;
        end
      end
      BSC_START: begin
        if (elapsed(timer, start_brake_time)) next_state = BSC_RUN;
      end
      BSC_RUN: begin
        if (!start_cmd && output_frequency <= engage_frequency_setting) begin
          next_release_req = 1'b0;
          next_flt_timer = 8'h00;
          next_state = BSC_DECEL;
        end
      end
      BSC_DECEL: begin
        next_timer = 8'h00;
        if (output_frequency <= release_frequency_setting) begin
          next_state = mode_fb ? BSC_WAIT_OFF : BSC_HOLD;
        end
      end
      BSC_WAIT_OFF: begin
        next_timer = 8'h00;
        if (!feedback) next_state = BSC_HOLD;
      end
      BSC_HOLD: begin
        if (elapsed(timer, stop_brake_time)) next_state = BSC_FINAL;
      end
      BSC_FINAL: begin
        if (stop_freq_hit) next_state = BSC_IDLE;
      end
      BSC_FAULT: begin
        next_release_req = 1'b0;
        if (!start_cmd) next_fault_flags = 4'h0;
        if (!start_cmd) next_state = BSC_IDLE;
      end
      default: next_state = BSC_IDLE;
    endcase
    // Fault checks common to several states.
    if (state == BSC_WAIT_CUR || state == BSC_DETECT) begin
      if (flt_timer > `BSC_FAULT_TIME) begin
        next_fault_flags[0] = 1'b1;
        next_state = BSC_FAULT;
        next_release_req = 1'b0;
      end
    end
    if (mode_fb && release_req && !feedback &&
        (state == BSC_START || state == BSC_RUN)) begin
      next_fault_flags[2] = 1'b1;
      next_state = BSC_FAULT;
      next_release_req = 1'b0;
    end
    if (mode_fb && feedback && (state == BSC_DECEL || state == BSC_WAIT_OFF) &&
        flt_timer > `BSC_FAULT_TIME) begin
      next_fault_flags[3] = 1'b1;
      next_state = BSC_FAULT;
    end
    if (next_state != state) next_timer = 8'h00;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state       <= BSC_IDLE;
      timer       <= 8'h00;
      flt_timer   <= 8'h00;
      fault_flags <= 4'h0;
      release_req <= 1'b0;
      sec_latch   <= 1'b0;
    end else begin
      state       <= next_state;
      timer       <= next_timer;
      flt_timer   <= next_flt_timer;
      fault_flags <= next_fault_flags;
      release_req <= next_release_req;
      sec_latch   <= next_sec_latch;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Drive outputs, registered.

  logic [2:0] next_oc;
  integer k;

  // Output terminal 0 carries the request in its selected polarity; the selectors of terminals 1 and 2 stay zero, so those stay low.
  always_comb begin
    next_oc = 3'b000;
    for (k = 0; k < `BSC_N_OUTPUTS; k = k + 1) begin
      if (output_function_selectors[8*k +: 8] == `BSC_OUT_SEL_POS) next_oc[k] = release_req;
      if (output_function_selectors[8*k +: 8] == `BSC_OUT_SEL_NEG) next_oc[k] = !release_req;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      open_collector_output  <= 3'b000;
      accel_enable           <= 1'b0;
      hold_frequency         <= 1'b0;
      output_shutoff         <= 1'b1;
      trip                   <= 1'b0;
      second_function_active <= 1'b0;
    end else begin
      open_collector_output  <= next_oc;
      accel_enable           <= (state == BSC_RUN) || !seq_active;
      hold_frequency         <= seq_active && ((state == BSC_HOLD) || (state == BSC_WAIT_OFF) ||
                                (state == BSC_DETECT) || (state == BSC_START) ||
                                (state == BSC_WAIT_FB));
      output_shutoff         <= (state == BSC_FAULT) || (state == BSC_IDLE && !start_cmd);
      trip                   <= (state == BSC_FAULT);
      second_function_active <= sec_latch;
    end
  end
endmodule
`default_nettype wire
